// ===== design/emm_pkg.sv
// package: register map, field positions and carriers of the error monitor
package emm_pkg;
  // ==========================================================
  // register pages of the micro-port
  localparam logic [3:0] PG_CFG = 4'h1; // code words and masks
  localparam logic [3:0] PG_MNT = 4'h2; // insertion, accumulate
  localparam logic [3:0] PG_CNT = 4'h4; // counters and vector
  localparam logic [3:0] PG_SLOT_LO = 4'h7; // slots 0..15
  localparam logic [3:0] PG_SLOT_HI = 4'h8; // slots 16..31
  localparam logic [3:0] PG_TXB0 = 4'h9;
  localparam logic [3:0] PG_TXB1 = 4'hA;
  localparam logic [3:0] PG_RXB0 = 4'hB;
  localparam logic [3:0] PG_RXB1 = 4'hC;
  // ==========================================================
  // addresses within a page
  localparam logic [4:0] A_INS = 5'h10;
  localparam logic [4:0] A_ACC = 5'h12;
  localparam logic [4:0] A_CIW = 5'h17;
  localparam logic [4:0] A_CDW = 5'h18;
  localparam logic [4:0] A_CDM = 5'h19;
  localparam logic [4:0] A_MSK0 = 5'h1B;
  localparam logic [4:0] A_MSK3 = 5'h1E;
  localparam logic [4:0] A_VEC = 5'h12;
  localparam logic [4:0] A_BER = 5'h18;
  localparam logic [4:0] A_RAC = 5'h19;
  localparam logic [4:0] A_AWC = 5'h1A;
  localparam logic [4:0] A_VLO = 5'h1C;
  localparam logic [4:0] A_VHI = 5'h1D;
  localparam logic [4:0] A_EBC = 5'h1E;
  localparam logic [4:0] A_CRC = 5'h1F;
  localparam int A_WIN = 4; // address bit that opens a 16-entry window
  // ==========================================================
  // field positions
  localparam int V_CNT = 5; // vector: counter indication
  localparam int V_OVF = 4; // vector: counter overflow
  localparam int V_MNT = 1; // vector: maintenance
  localparam int M0_ALIGN_ERROR_EVENT_IRQ = 2;
  localparam int M0_VIOLATION_OVERFLOW_IRQ = 1;
  localparam int M1_EBI = 7;
  localparam int M1_CRC_EVENT_IRQ = 6;
  localparam int M1_VIOLATION_EVENT_IRQ = 4;
  localparam int M1_REMOTE_ALARM_CRC_EVENT_IRQ = 3;
  localparam int M1_BERI = 2;
  localparam int M2_EBO = 7;
  localparam int M2_CRC_OVERFLOW_IRQ = 6;
  localparam int M2_ALIGN_ERROR_OVERFLOW_IRQ = 4;
  localparam int M2_REMOTE_ALARM_CRC_OVERFLOW_IRQ = 3;
  localparam int M2_BERO = 2;
  localparam int M3_STOP = 2;
  localparam int M3_STRT = 1;
  localparam int M3_DATA = 0;
  localparam int INS_LOS = 4; // insertion: bits 3..0 other errors
  localparam int ACC_HALT0 = 0; // accumulate: halt mode, buffer 0/1
  localparam int ACC_BEGIN0 = 2; // begin mode, buffer 0/1
  localparam int ACC_MIS0 = 4; // trigger on mismatch, buffer 0/1
  localparam int SC_TXB0 = 0; // slot word: tx buffer 0/1 attach
  localparam int SC_RXB0 = 2; // slot word: rx buffer 0/1 attach
  localparam int SC_DET = 6;
  localparam int SC_INS = 7;
  localparam int NFAS_RAI = 3;
  // ==========================================================
  // reset values and limits
  localparam logic [31:0] MSK_RST = 32'hFFFF_FF00;
  localparam logic [1:0] CAP_RST = 2'h3;
  localparam logic [7:0] C8_MAX = 8'hFF;
  localparam logic [15:0] C16_MAX = 16'hFFFF;
  localparam logic [1:0] BUF_FULL = 2'h2;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [4:0] slot; // time slot 0..31
    logic [3:0] frame; // frame within the crc-4 multiframe
    logic [7:0] data;
  } emm_byte_s;
  typedef struct packed {
    logic inject_signal_loss;
    logic inject_nonalign_error;
    logic inject_align_error;
    logic inject_crc_error;
    logic inject_violation;
  } emm_inject_s;
endpackage

// ===== design/emm_monitor.sv
// error counters, error insertion, circular buffers and code match
`timescale 1ns/10ps
module emm_monitor
  import emm_pkg::*;
#(
  parameter int SLOTS = 32,
  parameter int BUF_DEPTH = 16
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] host_page,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic irq_n,
  input wire logic rx_valid,
  input wire emm_pkg::emm_byte_s rx_byte,
  input wire logic rx_fas_valid,
  input wire logic [2:0] rx_fas_errbits,
  input wire logic rx_bpv,
  input wire logic rx_crc_err,
  input wire logic rx_ebit_err,
  input wire logic rx_nfas_valid,
  input wire logic [7:0] rx_nfas,
  input wire logic rx_ebit_valid,
  input wire logic rx_ebit,
  input wire logic tx_in_valid,
  input wire emm_pkg::emm_byte_s tx_in,
  output logic tx_in_ready,
  output logic tx_out_valid,
  output emm_pkg::emm_byte_s tx_out,
  input wire logic tx_out_ready,
  output emm_pkg::emm_inject_s inject,
  output logic tx_encode_en
);
  import emm_pkg::*;

  // ==========================================================
  // elaboration checks
  // the page map gives exactly 32 slot words and 16-byte buffers
  if (SLOTS != 32 || BUF_DEPTH != 16)
  begin : g_bad_size
    $error("emm_monitor serves only 32 slots and 16-byte buffers");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ins; // error insertion control
    logic [7:0] acc; // buffer accumulate control
    logic [7:0] ciw; // code insert word
    logic [7:0] cdw; // code detect word
    logic [7:0] detect_mask_alias; // code detect mask
    logic [3:0][7:0] msk; // mask words, one = masked
    logic [7:0] vec; // interrupt vector
    logic [7:0] awc; // errored alignment words
    logic [7:0] ber; // bit errors in alignment words
    logic [7:0] rac; // remote alarm with e-bit error
    logic [7:0] ebc; // e-bit errors
    logic [7:0] crc; // crc-4 errors
    logic [15:0] vio; // violations
    logic rai; // last received remote alarm bit
    logic [1:0] cap; // per rx buffer: capturing
    logic [SLOTS-1:0][7:0] sc; // per-slot control words
    logic [1:0][BUF_DEPTH-1:0][7:0] txb;
    logic [1:0][BUF_DEPTH-1:0][7:0] rxb;
    emm_byte_s [1:0] q; // two-entry tx buffer, entry 0 is head
    logic [1:0] cnt; // tx buffer fill
    logic ovld;
    logic in_rdy;
    logic [7:0] rdat;
    logic rval;
    logic irq_n;
    logic enc_en;
  } emm_state_s;

  emm_state_s s; // registered state
  emm_state_s next_s; // next state
  logic cnt_wr; // counter page write this cycle
  logic ev_cnt; // unmasked counter indication
  logic ev_ovf; // unmasked counter overflow
  logic ev_mnt; // unmasked maintenance event
  logic [8:0] ber_sum; // bit count sum with carry
  logic match; // masked compare of rx byte
  logic [1:0] hit; // per rx buffer trigger
  logic [1:0] ev_stop; // halt events per buffer
  logic [1:0] ev_start; // begin events per buffer
  logic pop; // tx head taken
  logic push; // tx byte accepted
  logic [1:0] cnt_m; // fill after pop
  emm_byte_s tx_item; // tx byte after substitution
  logic [5:0] sidx; // slot word index incl. page select
  logic [7:0] rd; // read mux

  assign cnt_wr = host_wr && (host_page == PG_CNT);

  // ==========================================================
  // next state
  always_comb
  begin
    next_s = s;
    ev_cnt = 1'b0;
    ev_ovf = 1'b0;
    ev_mnt = 1'b0;
    ev_stop = 2'h0;
    ev_start = 2'h0;
    hit = 2'h0;
    rd = 8'h00;
    sidx = {1'b0, host_page == PG_SLOT_HI, host_addr[3:0]};
    ber_sum = {1'b0, s.ber} + {6'h00, rx_fas_errbits};
    match = (((rx_byte.data ^ s.cdw) & s.detect_mask_alias) == 8'h00);
    // errored alignment words: one per word, not per bit
    if (rx_fas_valid && (rx_fas_errbits != 3'h0))
    begin
      next_s.awc = s.awc + 8'h01;
      ev_cnt |= !s.msk[0][M0_ALIGN_ERROR_EVENT_IRQ];
      ev_ovf |= (s.awc == C8_MAX) && !s.msk[2][M2_ALIGN_ERROR_OVERFLOW_IRQ];
    end
    // bit errors: every bad bit of the word adds one
    if (rx_fas_valid)
    begin
      next_s.ber = ber_sum[7:0];
      // an odd addend is what flips the lsb
      ev_cnt |= rx_fas_errbits[0] && !s.msk[1][M1_BERI];
      ev_ovf |= ber_sum[8] && !s.msk[2][M2_BERO];
    end
    // violations; the line decoder already drops substitutions
    if (rx_bpv)
    begin
      next_s.vio = s.vio + 16'h0001;
      ev_cnt |= !s.msk[1][M1_VIOLATION_EVENT_IRQ];
      ev_ovf |= (s.vio == C16_MAX) && !s.msk[0][M0_VIOLATION_OVERFLOW_IRQ];
    end
    // crc-4 errors, at most two per multiframe
    if (rx_crc_err)
    begin
      next_s.crc = s.crc + 8'h01;
      ev_cnt |= !s.msk[1][M1_CRC_EVENT_IRQ];
      ev_ovf |= (s.crc == C8_MAX) && !s.msk[2][M2_CRC_OVERFLOW_IRQ];
    end
    // e-bit errors
    if (rx_ebit_err)
    begin
      next_s.ebc = s.ebc + 8'h01;
      ev_cnt |= !s.msk[1][M1_EBI];
      ev_ovf |= (s.ebc == C8_MAX) && !s.msk[2][M2_EBO];
    end
    // remote alarm bit is kept from the latest non-alignment word
    if (rx_nfas_valid)
    begin
      next_s.rai = rx_nfas[NFAS_RAI];
    end
    if (rx_ebit_valid && !rx_ebit && s.rai)
    begin
      next_s.rac = s.rac + 8'h01;
      ev_cnt |= !s.msk[1][M1_REMOTE_ALARM_CRC_EVENT_IRQ];
      ev_ovf |= (s.rac == C8_MAX) && !s.msk[2][M2_REMOTE_ALARM_CRC_OVERFLOW_IRQ];
    end
    // receive slots: buffer capture and pattern triggers
    if (rx_valid)
    begin
      for (int k = 0; k < 2; k++)
      begin
        if (s.sc[rx_byte.slot][SC_RXB0 + k])
        begin
          hit[k] = match ^ s.acc[ACC_MIS0 + k];
          // begin mode: the trigger byte is the first one kept
          if (s.acc[ACC_BEGIN0 + k] && !s.cap[k] && hit[k])
          begin
            next_s.cap[k] = 1'b1;
            ev_start[k] = 1'b1;
          end
          // frame number is the buffer index, so each multiframe
          // lands on the same 16 bytes and overwrites the last
          if (s.cap[k] || ev_start[k])
          begin
            next_s.rxb[k][rx_byte.frame] = rx_byte.data;
          end
          // halt mode: the trigger byte is stored, then capture ends
          if (s.acc[ACC_HALT0 + k] && s.cap[k] && hit[k])
          begin
            next_s.cap[k] = 1'b0;
            ev_stop[k] = 1'b1;
          end
        end
      end
      ev_mnt |= (|ev_stop) && !s.msk[3][M3_STOP];
      ev_mnt |= (|ev_start) && !s.msk[3][M3_STRT];
      if (s.sc[rx_byte.slot][SC_DET] && match)
      begin
        ev_mnt |= !s.msk[3][M3_DATA];
      end
    end
    // transmit substitution; code insert has the last word
    tx_item = tx_in;
    for (int k = 0; k < 2; k++)
    begin
      if (s.sc[tx_in.slot][SC_TXB0 + k])
      begin
        tx_item.data = s.txb[k][tx_in.frame];
      end
    end
    if (s.sc[tx_in.slot][SC_INS])
    begin
      tx_item.data = s.ciw;
    end
    // two-entry buffer; ready is registered so it lags a pop by one
    pop = s.ovld && tx_out_ready;
    push = tx_in_valid && s.in_rdy;
    cnt_m = s.cnt - {1'b0, pop};
    if (pop)
    begin
      next_s.q[0] = s.q[1];
    end
    if (push)
    begin
      next_s.q[cnt_m[0]] = tx_item;
    end
    next_s.cnt = cnt_m + {1'b0, push};
    next_s.ovld = (next_s.cnt != 2'h0);
    next_s.in_rdy = (next_s.cnt != BUF_FULL);
    // host access; a write wins over a same-cycle count
    case (host_page)
      PG_CFG:
      begin
        case (host_addr)
          A_CIW: rd = s.ciw;
          A_CDW: rd = s.cdw;
          A_CDM: rd = s.detect_mask_alias;
          default:
          begin
            if (host_addr >= A_MSK0 && host_addr <= A_MSK3)
            begin
              rd = s.msk[2'(host_addr - A_MSK0)];
              if (host_wr)
              begin
                next_s.msk[2'(host_addr - A_MSK0)] = host_wdata;
              end
            end
          end
        endcase
        if (host_wr && host_addr == A_CIW) next_s.ciw = host_wdata;
        if (host_wr && host_addr == A_CDW) next_s.cdw = host_wdata;
        if (host_wr && host_addr == A_CDM) next_s.detect_mask_alias = host_wdata;
      end
      PG_MNT:
      begin
        if (host_addr == A_INS)
        begin
          rd = s.ins;
          if (host_wr) next_s.ins = host_wdata;
        end
        if (host_addr == A_ACC)
        begin
          rd = s.acc;
          // rewriting re-arms: begin mode waits, others capture
          if (host_wr)
          begin
            next_s.acc = host_wdata;
            next_s.cap[0] = !host_wdata[ACC_BEGIN0];
            next_s.cap[1] = !host_wdata[ACC_BEGIN0 + 1];
          end
        end
      end
      PG_CNT:
      begin
        case (host_addr)
          A_VEC: rd = s.vec;
          A_BER: rd = s.ber;
          A_RAC: rd = s.rac;
          A_AWC: rd = s.awc;
          A_VLO: rd = s.vio[7:0];
          A_VHI: rd = s.vio[15:8];
          A_EBC: rd = s.ebc;
          A_CRC: rd = s.crc;
          default: rd = 8'h00;
        endcase
        // presets; the low violation byte goes first so a carry
        // between the two writes cannot corrupt the high byte
        if (cnt_wr && host_addr == A_BER) next_s.ber = host_wdata;
        if (cnt_wr && host_addr == A_RAC) next_s.rac = host_wdata;
        if (cnt_wr && host_addr == A_AWC) next_s.awc = host_wdata;
        if (cnt_wr && host_addr == A_VLO) next_s.vio[7:0] = host_wdata;
        if (cnt_wr && host_addr == A_VHI) next_s.vio[15:8] = host_wdata;
        if (cnt_wr && host_addr == A_EBC) next_s.ebc = host_wdata;
        if (cnt_wr && host_addr == A_CRC) next_s.crc = host_wdata;
        // read clears the vector
        if (host_rd && host_addr == A_VEC) next_s.vec = 8'h00;
      end
      PG_SLOT_LO, PG_SLOT_HI:
      begin
        if (host_addr[A_WIN])
        begin
          rd = s.sc[sidx[4:0]];
          if (host_wr) next_s.sc[sidx[4:0]] = host_wdata;
        end
      end
      PG_TXB0, PG_TXB1:
      begin
        if (host_addr[A_WIN])
        begin
          rd = s.txb[host_page == PG_TXB1][host_addr[3:0]];
          if (host_wr)
          begin
            next_s.txb[host_page == PG_TXB1][host_addr[3:0]] = host_wdata;
          end
        end
      end
      PG_RXB0, PG_RXB1:
      begin
        if (host_addr[A_WIN])
        begin
          rd = s.rxb[host_page == PG_RXB1][host_addr[3:0]];
        end
      end
      default: rd = 8'h00;
    endcase
    // events set after the clear, so a set in the read cycle wins
    next_s.vec[V_CNT] = next_s.vec[V_CNT] | ev_cnt;
    next_s.vec[V_OVF] = next_s.vec[V_OVF] | ev_ovf;
    next_s.vec[V_MNT] = next_s.vec[V_MNT] | ev_mnt;
    next_s.irq_n = !(|next_s.vec);
    next_s.enc_en = !next_s.ins[INS_LOS];
    next_s.rdat = rd;
    next_s.rval = host_rd;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.msk <= MSK_RST;
      s.cap <= CAP_RST;
      s.in_rdy <= 1'b1;
      s.irq_n <= 1'b1;
      s.enc_en <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign host_rdata = s.rdat;
  assign host_rvalid = s.rval;
  assign irq_n = s.irq_n;
  assign tx_in_ready = s.in_rdy;
  assign tx_out_valid = s.ovld;
  assign tx_out = s.q[0];
  assign inject = emm_inject_s'(s.ins[4:0]);
  assign tx_encode_en = s.enc_en;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence fas_bad_s;
    rx_fas_valid && (rx_fas_errbits != 3'h0) && !cnt_wr;
  endsequence
  sequence stop_hit_s;
    rx_valid && s.sc[rx_byte.slot][SC_RXB0] && s.acc[ACC_HALT0]
      && s.cap[0] && (match ^ s.acc[ACC_MIS0])
      && !(host_wr && host_page == PG_MNT);
  endsequence

  awc_step_a: assert property (
    fas_bad_s |=> s.awc == $past(s.awc) + 8'h01)
    else $error("errored alignment word not counted");
  awc_wrap_a: assert property (
    fas_bad_s and (s.awc == C8_MAX) and !s.msk[2][M2_ALIGN_ERROR_OVERFLOW_IRQ]
      |=> (s.awc == 8'h00) && s.vec[V_OVF] ##1 !irq_n)
    else $error("alignment overflow not flagged");
  vio_step_a: assert property (
    rx_bpv && !cnt_wr |=> s.vio == $past(s.vio) + 16'h0001)
    else $error("violation not counted");
  crc_step_a: assert property (
    rx_crc_err && !cnt_wr |=> s.crc == $past(s.crc) + 8'h01)
    else $error("crc error not counted");
  ber_bits_a: assert property (
    rx_fas_valid && !cnt_wr
      |=> s.ber == 8'($past(s.ber) + $past(rx_fas_errbits)))
    else $error("bit errors not added");
  rac_count_a: assert property (
    rx_ebit_valid && !rx_ebit && s.rai && !cnt_wr
      |=> s.rac == $past(s.rac) + 8'h01)
    else $error("remote alarm count missed");
  los_encode_a: assert property (
    s.ins[INS_LOS] |-> !tx_encode_en && inject.inject_signal_loss)
    else $error("loss insertion did not stop encoding");
  halt_stop_a: assert property (
    stop_hit_s |=> !s.cap[0] && (s.vec[V_MNT] || s.msk[3][M3_STOP]))
    else $error("halt mode did not stop capture");
  code_ins_a: assert property (
    tx_in_valid && tx_in_ready && s.sc[tx_in.slot][SC_INS]
      && !tx_out_valid |=> tx_out_valid && tx_out.data == $past(s.ciw))
    else $error("code insert word not sent");
  vec_clear_a: assert property (
    host_rd && host_page == PG_CNT && host_addr == A_VEC
      && !ev_cnt && !ev_ovf && !ev_mnt |=> irq_n && s.vec == 8'h00)
    else $error("vector read did not release interrupt");
endmodule // emm_monitor

// ===== sim/emm_line_model.sv
// far-end line model that drains the transmit stream
`timescale 1ns/10ps
module emm_line_model
  import emm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic stall,
  input wire logic tx_out_valid,
  input wire emm_pkg::emm_byte_s tx_out,
  output logic tx_out_ready
);
  // ==========================================
  // line side
  emm_byte_s seen[$]; // bytes taken, in order
  // ready falls only on a stall that the bench asks for
  assign tx_out_ready = !stall;
  // a byte leaves wherever valid meets ready at an edge
  always @(posedge clock)
    if (nrst && tx_out_valid && tx_out_ready)
      seen.push_back(tx_out);
endmodule // emm_line_model

// ===== sim/emm_monitor_tb.sv
// self-checking bench of the error monitor block
`timescale 1ns/10ps
module emm_monitor_tb;
  import emm_pkg::*;
  // ==========================================
  // driven and watched signals
  logic clock = 1'b0, nrst = 1'b0, stall = 1'b0;
  logic [3:0] host_page = 4'h0;
  logic [4:0] host_addr = 5'h00;
  logic [7:0] host_wdata = 8'h00, rx_nfas = 8'h00, host_rdata;
  logic host_wr = 1'b0, host_rd = 1'b0, host_rvalid, irq_n;
  logic rx_valid = 1'b0, rx_fas_valid = 1'b0, rx_bpv = 1'b0;
  logic rx_crc_err = 1'b0, rx_ebit_err = 1'b0, rx_nfas_valid = 1'b0;
  logic rx_ebit_valid = 1'b0, rx_ebit = 1'b0, tx_in_valid = 1'b0;
  logic [2:0] rx_fas_errbits = 3'h0;
  logic tx_in_ready, tx_out_valid, tx_out_ready, tx_encode_en;
  emm_byte_s rx_byte = '0, tx_in = '0, tx_out;
  emm_inject_s inject;
  int err_total = 0, cmp_count = 0, cyc = 0;
  // ==========================================
  // block and far end
  emm_monitor u_emm_monitor (
    .clock(clock), .nrst(nrst), .host_page(host_page),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .irq_n(irq_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_fas_valid(rx_fas_valid), .rx_fas_errbits(rx_fas_errbits),
    .rx_bpv(rx_bpv), .rx_crc_err(rx_crc_err), .rx_ebit_err(rx_ebit_err),
    .rx_nfas_valid(rx_nfas_valid), .rx_nfas(rx_nfas),
    .rx_ebit_valid(rx_ebit_valid), .rx_ebit(rx_ebit),
    .tx_in_valid(tx_in_valid), .tx_in(tx_in), .tx_in_ready(tx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out(tx_out),
    .tx_out_ready(tx_out_ready), .inject(inject),
    .tx_encode_en(tx_encode_en)
  );
  emm_line_model u_emm_line_model (
    .clock(clock), .nrst(nrst), .stall(stall),
    .tx_out_valid(tx_out_valid), .tx_out(tx_out),
    .tx_out_ready(tx_out_ready)
  );
  // ==========================================
  // 25 MHz clock and hang guard
  always #20 clock = ~clock;
  // the run needs under two hundred cycles, so 3000 means a hang
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  // ==========================================
  // shared helpers
  task tick; // inputs move 1 ns after the edge, never on it
    @(posedge clock);
    #1;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s); // one-cycle event strobe
    tick;
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask
  task wr(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
    tick;
    {host_page, host_addr, host_wdata, host_wr} = {p, a, d, 1'b1};
    tick;
    host_wr = 1'b0;
  endtask
  // rvalid stands one cycle only, so the read is judged at once
  task rd(input logic [3:0] p, input logic [4:0] a, input logic [7:0] e,
          input string n);
    tick;
    {host_page, host_addr, host_rd} = {p, a, 1'b1};
    tick;
    host_rd = 1'b0;
    chk("rvalid", 8'h01, 8'(host_rvalid));
    chk(n, e, host_rdata);
  endtask
  task rxb(input logic [4:0] s, input logic [7:0] d); // frame 3 byte
    tick;
    rx_byte = '{s, 4'h3, d};
    rx_valid = 1'b1;
    tick;
    rx_valid = 1'b0;
  endtask
  task txs(input logic [4:0] s, input logic [7:0] d); // held until taken
    tick;
    tx_in = '{s, 4'h0, d};
    tx_in_valid = 1'b1;
    // ready is judged settled, ahead of the edge that takes the byte
    while (tx_in_ready !== 1'b1)
      tick;
    tick;
    tx_in_valid = 1'b0;
  endtask
  // ==========================================
  // scenarios
  task t_reset; // masks and idle outputs after reset
    chk("irq_n", 8'h01, 8'(irq_n));
    rd(PG_CFG, A_MSK0, 8'h00, "mask0");
    rd(PG_CFG, A_MSK3, 8'hFF, "mask3");
  endtask
  task t_align; // clean word ignored, errored word wraps FF to 00
    wr(PG_CFG, A_MSK0 + 5'h2, 8'hEF); // open the align overflow
    wr(PG_CNT, A_AWC, 8'hFF);
    pulse(rx_fas_valid);
    rx_fas_errbits = 3'h3;
    pulse(rx_fas_valid);
    chk("irq_n", 8'h00, 8'(irq_n));
    rd(PG_CNT, A_AWC, 8'h00, "align cnt");
    rd(PG_CNT, A_BER, 8'h03, "bit err cnt");
    rd(PG_CNT, A_VEC, 8'h30, "vec");
    chk("irq_n", 8'h01, 8'(irq_n));
  endtask
  task t_viol; // carry into the high byte, then full wrap
    wr(PG_CNT, A_VLO, 8'hFF);
    wr(PG_CNT, A_VHI, 8'h00);
    pulse(rx_bpv);
    rd(PG_CNT, A_VHI, 8'h01, "viol hi");
    wr(PG_CNT, A_VLO, 8'hFF);
    wr(PG_CNT, A_VHI, 8'hFF);
    pulse(rx_bpv);
    rd(PG_CNT, A_VLO, 8'h00, "viol lo");
    rd(PG_CNT, A_VHI, 8'h00, "viol hi");
    rd(PG_CNT, A_VEC, 8'h10, "vec");
  endtask
  task t_crc; // crc event open, e-bit event left masked
    wr(PG_CFG, A_MSK0 + 5'h1, 8'hBF);
    pulse(rx_crc_err);
    pulse(rx_crc_err);
    rd(PG_CNT, A_CRC, 8'h02, "crc cnt");
    rd(PG_CNT, A_VEC, 8'h20, "vec");
    pulse(rx_ebit_err);
    rd(PG_CNT, A_EBC, 8'h01, "ebit cnt");
    rd(PG_CNT, A_VEC, 8'h00, "vec");
  endtask
  task t_rac; // alarm set: a zero e-bit counts, a one does not
    rx_nfas = 8'h08;
    pulse(rx_nfas_valid);
    pulse(rx_ebit_valid);
    rx_ebit = 1'b1;
    pulse(rx_ebit_valid);
    rd(PG_CNT, A_RAC, 8'h01, "alarm cnt");
  endtask
  task t_insert; // each insertion bit alone
    for (int i = 0; i < 5; i++)
    begin
      wr(PG_MNT, A_INS, 8'h01 << i);
      tick;
      chk("inject", 8'h01 << i, 8'(inject));
      chk("encode", i == 4 ? 8'h00 : 8'h01, 8'(tx_encode_en));
    end
    wr(PG_MNT, A_INS, 8'h00);
  endtask
  task t_code; // flagged slot carries the code; a stall fills the buffer
    wr(PG_CFG, A_CIW, 8'hA5);
    wr(PG_SLOT_LO, 5'h13, 8'h80);
    stall = 1'b1;
    txs(5'h03, 8'h00);
    txs(5'h04, 8'h3C);
    chk("tx ready", 8'h00, 8'(tx_in_ready)); // both entries held
    stall = 1'b0;
    for (int n = 0; n < 9 && u_emm_line_model.seen.size() < 2; n++)
      tick;
    chk("taken", 8'h02, 8'(u_emm_line_model.seen.size()));
    chk("slot 3", 8'hA5, u_emm_line_model.seen[0].data);
    chk("slot 4", 8'h3C, u_emm_line_model.seen[1].data);
  endtask
  task t_detect; // masked code match and receive buffer capture
    wr(PG_CFG, A_CDW, 8'h5A);
    wr(PG_CFG, A_CDM, 8'hF0);
    wr(PG_CFG, A_MSK3, 8'hFE); // open the data match event
    wr(PG_SLOT_LO, 5'h15, 8'h40); // detect on slot 5
    wr(PG_SLOT_LO, 5'h16, 8'h04); // rx buffer 0 on slot 6
    rxb(5'h05, 8'h6A); // differs inside the mask
    rxb(5'h06, 8'h5A); // slot 6 is not flagged
    rd(PG_CNT, A_VEC, 8'h00, "vec");
    rd(PG_RXB0, 5'h13, 8'h5A, "rx buf");
    rxb(5'h05, 8'h53); // differs outside the mask only
    chk("irq_n", 8'h00, 8'(irq_n));
    rd(PG_CNT, A_VEC, 8'h02, "vec");
  endtask
  task t_accum; // halt and begin modes, then a tx buffer slot
    wr(PG_CFG, A_MSK3, 8'hF8); // open stop, start and data events
    wr(PG_MNT, A_ACC, 8'h29); // halt buf 0, begin buf 1 on mismatch
    wr(PG_SLOT_LO, 5'h17, 8'h0C); // both rx buffers on slot 7
    rxb(5'h07, 8'h11); // mismatch starts buffer 1
    rd(PG_CNT, A_VEC, 8'h02, "vec start");
    rxb(5'h07, 8'h5F); // match stops buffer 0
    rd(PG_CNT, A_VEC, 8'h02, "vec stop");
    rxb(5'h07, 8'h22); // only buffer 1 still records
    rd(PG_RXB0, 5'h13, 8'h5F, "rx buf0");
    rd(PG_RXB1, 5'h13, 8'h22, "rx buf1");
    wr(PG_TXB1, 5'h10, 8'h77);
    wr(PG_SLOT_LO, 5'h18, 8'h02); // tx buffer 1 on slot 8
    txs(5'h08, 8'h00);
    for (int n = 0; n < 9 && u_emm_line_model.seen.size() < 3; n++)
      tick;
    chk("tx buf", 8'h77, u_emm_line_model.seen[2].data);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    #1 nrst = 1'b1;
    t_reset;
    t_align;
    t_viol;
    t_crc;
    t_rac;
    t_insert;
    t_code;
    t_detect;
    t_accum;
    tally_and_finish;
  end
endmodule // emm_monitor_tb
